// ### hw/shc_pkg.sv
package shc_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFF_CFG      = 8'h00;
   localparam logic [7:0]  OFF_PRIO1    = 8'h04;
   localparam logic [7:0]  OFF_PRIO2    = 8'h08;
   localparam logic [7:0]  OFF_PRIO3    = 8'h0C;
   localparam logic [7:0]  OFF_STATE    = 8'h10;
   localparam logic [7:0]  OFF_EVT      = 8'h14;
   localparam logic [7:0]  OFF_EVT_MASK = 8'h18;

   // ----------------------------------------
   // Writable bits and reset values
   // ----------------------------------------
   localparam logic [31:0] RESET_VAL    = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK    = 32'h0000_000B;
   localparam logic [31:0] PRIO1_WMASK  = 32'h00F0_F0F0;
   localparam logic [31:0] PRIO2_WMASK  = 32'hF000_0000;
   localparam logic [31:0] PRIO3_WMASK  = 32'hF0F0_0000;
   localparam logic [31:0] STATE_WMASK  = 32'h0007_FD8B;
   localparam logic [31:0] EVT_WMASK    = 32'h0000_0007;
   localparam logic [7:0]  PRIO_KEEP    = 8'hF0;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CFG_MISALIGN = 3;
   localparam int CFG_UNPRIV   = 1;
   localparam int CFG_THREAD   = 0;
   localparam int ST_EN_LO     = 16;
   localparam int ST_PEND_SVC  = 15;
   localparam int ST_ACT_TICK  = 11;
   localparam int EV_MISALIGN  = 0;
   localparam int EV_ESCALATE  = 1;
   localparam int EV_TRIG_DENY = 2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {SHC_FK_MEMPROT, SHC_FK_BUS, SHC_FK_ILLEGAL} shc_fault_t;
   typedef enum logic [1:0] {SHC_SZ_BYTE, SHC_SZ_HALF, SHC_SZ_WORD, SHC_SZ_DOUBLE} shc_size_t;

   // Byte-lane merge of a write into writable bits
   function automatic logic [31:0] shc_merge(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb,
                                             input logic [31:0] wmask);
      logic [31:0] lanes;
      lanes = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         lanes[i*8 +: 8] = {8{strb[i]}};
      end
      return (old & ~(lanes & wmask)) | (wdata & lanes & wmask);
   endfunction : shc_merge

endpackage : shc_pkg

// ### hw/shc_ctl_if.sv
`timescale 1ns/1ps
interface shc_ctl_if;
   logic       cfg_misalign;
   logic       cfg_unpriv;
   logic       cfg_thread;
   logic [2:0] handler_en;
   logic       ev_misalign;
   logic       ev_escalate;
   logic       ev_trig_deny;

   modport regs (output cfg_misalign, cfg_unpriv, cfg_thread, handler_en,
                 input  ev_misalign, ev_escalate, ev_trig_deny);
   modport route (input  cfg_misalign, cfg_unpriv, cfg_thread, handler_en,
                  output ev_misalign, ev_escalate, ev_trig_deny);
endinterface : shc_ctl_if

// ### hw/shc_fault_route.sv
`timescale 1ns/1ps
module shc_fault_route
   import shc_pkg::*;
(
   input  logic       pclk,
   input  logic       presetn,
   shc_ctl_if.route   ctl,
   input  logic       acc_valid,
   input  shc_size_t  acc_size,
   input  logic       acc_multi,
   input  logic [1:0] acc_addr,
   input  logic       fault_valid,
   input  shc_fault_t fault_kind,
   input  logic       trig_req,
   input  logic       trig_unpriv,
   input  logic       ret_req,
   input  logic       ret_to_thread,
   input  logic       nest_active,
   output logic       misalign_fault,
   output logic       fault_take,
   output logic       fault_to_hard,
   output shc_fault_t fault_kind_out,
   output logic       trig_grant,
   output logic       trig_deny,
   output logic       thread_ok,
   output logic       thread_deny
);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire logic odd_half  = acc_size == SHC_SZ_HALF && acc_addr[0];
   wire logic odd_word  = acc_size == SHC_SZ_WORD && acc_addr != 2'b00;
   wire logic odd_big   = (acc_multi || acc_size == SHC_SZ_DOUBLE) && acc_addr != 2'b00;
   wire logic trap      = acc_valid && (odd_big
                          || (ctl.cfg_misalign && (odd_half || odd_word)));
   wire logic any_fault = trap || fault_valid;
   wire shc_fault_t kind = trap ? SHC_FK_ILLEGAL : fault_kind;
   logic en_kind;
   always_comb begin
      unique case (kind)
         SHC_FK_MEMPROT: en_kind = ctl.handler_en[0];
         SHC_FK_BUS:     en_kind = ctl.handler_en[1];
         SHC_FK_ILLEGAL: en_kind = ctl.handler_en[2];
         default:        en_kind = 1'b0;
      endcase
   end
   wire logic to_hard   = any_fault && !en_kind;
   wire logic t_allow   = trig_req && (!trig_unpriv || ctl.cfg_unpriv);
   wire logic t_deny    = trig_req && !t_allow;
   wire logic th_allow  = ret_req && ret_to_thread
                          && (ctl.cfg_thread || !nest_active);

   // ----------------------------------------
   // Registered answers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         misalign_fault <= 1'b0;
         fault_take     <= 1'b0;
         fault_to_hard  <= 1'b0;
         fault_kind_out <= SHC_FK_MEMPROT;
         trig_grant     <= 1'b0;
         trig_deny      <= 1'b0;
         thread_ok      <= 1'b0;
         thread_deny    <= 1'b0;
      end else begin
         misalign_fault <= trap;
         fault_take     <= any_fault;
         fault_to_hard  <= to_hard;
         fault_kind_out <= kind;
         trig_grant     <= t_allow;
         trig_deny      <= t_deny;
         thread_ok      <= th_allow;
         thread_deny    <= ret_req && ret_to_thread && !th_allow;
      end
   end

   assign ctl.ev_misalign  = misalign_fault;
   assign ctl.ev_escalate  = fault_to_hard;
   assign ctl.ev_trig_deny = trig_deny;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_big_always;
      acc_valid && acc_size == SHC_SZ_DOUBLE && acc_addr != 2'b00 |=> misalign_fault;
   endproperty
   a_big_always: assert property (p_big_always) else $error("odd doubleword not trapped");

   property p_trap_off;
      acc_valid && !ctl.cfg_misalign && !acc_multi && acc_size == SHC_SZ_HALF
      |=> !misalign_fault;
   endproperty
   a_trap_off: assert property (p_trap_off) else $error("halfword trapped while off");

   property p_escalate;
      fault_valid && !trap && fault_kind == SHC_FK_BUS && !ctl.handler_en[1]
      |=> fault_take && fault_to_hard;
   endproperty
   a_escalate: assert property (p_escalate) else $error("bus fault not escalated");

   property p_trig;
      trig_req && trig_unpriv && !ctl.cfg_unpriv |=> trig_deny && !trig_grant;
   endproperty
   a_trig: assert property (p_trig) else $error("unprivileged trigger not denied");

   property p_thread;
      ret_req && ret_to_thread && nest_active && !ctl.cfg_thread |=> thread_deny && !thread_ok;
   endproperty
   a_thread: assert property (p_thread) else $error("thread entry not denied");

endmodule : shc_fault_route

// ### hw/shc_handler_regs.sv
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - The misaligned trap bit makes odd halfword and word accesses raise an illegal-use fault.
// - Odd multiple-register and doubleword accesses always fault, whatever the trap bit.
// - The unprivileged trigger bit grants or denies user access to the trigger register.
// - Thread entry with the thread bit clear needs no other exception active.
// - Handler priorities span at most 0 to 255, with the level count set here.
// - All three priority registers take byte writes, one field alone.
// - Only the upper priority bits are kept; the lower ones read zero and drop writes.
// - Priority one holds illegal-use, bus error and memory protection fields from the top.
// - Priority two holds the supervisor call field in its top byte only.
// - Priority three holds system tick and deferred service fields in its top bytes.
// - Handler control bits 18 to 16 enable illegal-use, bus error and protection faults.
// - Pending bits 15 to 12 show and accept pending state of four exceptions.
// - Active bits show and accept the active state of seven exceptions.
// - A fault whose handler is disabled is taken as a hard fault.
module shc_handler_regs
   import shc_pkg::*;
(
   input  logic              pclk,
   input  logic              presetn,
   input  logic              psel,
   input  logic              penable,
   input  logic              pwrite,
   input  logic [ADDR_W-1:0] paddr,
   input  logic [31:0]       pwdata,
   input  logic [3:0]        pstrb,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  logic              acc_valid,
   input  shc_size_t         acc_size,
   input  logic              acc_multi,
   input  logic [1:0]        acc_addr,
   input  logic              fault_valid,
   input  shc_fault_t        fault_kind,
   input  logic              trig_req,
   input  logic              trig_unpriv,
   input  logic              ret_req,
   input  logic              ret_to_thread,
   input  logic              nest_active,
   input  logic [15:0]       core_state_set,
   input  logic [15:0]       core_state_clr,
   output logic              misalign_fault,
   output logic              fault_take,
   output logic              fault_to_hard,
   output shc_fault_t        fault_kind_out,
   output logic              trig_grant,
   output logic              trig_deny,
   output logic              thread_ok,
   output logic              thread_deny,
   output logic [7:0]        memprot_fault_priority,
   output logic [7:0]        bus_error_priority,
   output logic [7:0]        illegal_use_priority,
   output logic [7:0]        supervisor_call_priority,
   output logic [7:0]        deferred_service_priority,
   output logic [7:0]        system_tick_priority,
   output logic [18:0]       handler_state,
   output logic              irq
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [31:0] configuration_control;
   logic [31:0] handler_priority_one;
   logic [31:0] handler_priority_two;
   logic [31:0] handler_priority_three;
   logic [31:0] handler_control_state;
   logic [31:0] evt_status;
   logic [31:0] evt_mask;

   shc_ctl_if ctl ();

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire logic hit_cfg   = paddr == OFF_CFG;
   wire logic hit_p1    = paddr == OFF_PRIO1;
   wire logic hit_p2    = paddr == OFF_PRIO2;
   wire logic hit_p3    = paddr == OFF_PRIO3;
   wire logic hit_st    = paddr == OFF_STATE;
   wire logic hit_ev    = paddr == OFF_EVT;
   wire logic hit_em    = paddr == OFF_EVT_MASK;
   wire logic map_hit   = hit_cfg || hit_p1 || hit_p2 || hit_p3
                          || hit_st || hit_ev || hit_em;
   wire logic setup     = psel && !penable;
   wire logic access    = psel && penable;
   wire logic wr        = access && pwrite && map_hit;
   wire logic wr_cfg    = wr && hit_cfg;
   wire logic wr_p1     = wr && hit_p1;
   wire logic wr_p2     = wr && hit_p2;
   wire logic wr_p3     = wr && hit_p3;
   wire logic wr_st     = wr && hit_st;
   wire logic wr_ev     = wr && hit_ev;
   wire logic wr_em     = wr && hit_em;

   assign pready  = 1'b1;
   assign pslverr = access && !map_hit;

   // ----------------------------------------
   // Read selection
   // ----------------------------------------
   wire logic [31:0] rd_val =
      hit_cfg ? configuration_control  :
      hit_p1  ? handler_priority_one   :
      hit_p2  ? handler_priority_two   :
      hit_p3  ? handler_priority_three :
      hit_st  ? handler_control_state  :
      hit_ev  ? evt_status             :
      hit_em  ? evt_mask               :
      RESET_VAL;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= RESET_VAL;
      end else if (setup && !pwrite) begin
         prdata <= rd_val;
      end
   end

   // ----------------------------------------
   // Next values
   // ----------------------------------------
   wire logic [31:0] next_cfg =
      shc_merge(configuration_control, pwdata, pstrb, CFG_WMASK);
   wire logic [31:0] next_p1 =
      shc_merge(handler_priority_one, pwdata, pstrb, PRIO1_WMASK);
   wire logic [31:0] next_p2 =
      shc_merge(handler_priority_two, pwdata, pstrb, PRIO2_WMASK);
   wire logic [31:0] next_p3 =
      shc_merge(handler_priority_three, pwdata, pstrb, PRIO3_WMASK);
   wire logic [31:0] sw_state = wr_st
      ? shc_merge(handler_control_state, pwdata, pstrb, STATE_WMASK)
      : handler_control_state;
   wire logic [31:0] next_state =
      ((sw_state & ~{16'h0000, core_state_clr})
       | {16'h0000, core_state_set}) & STATE_WMASK;
   wire logic [31:0] evt_clr  = shc_merge(RESET_VAL, pwdata, pstrb, EVT_WMASK);
   wire logic [31:0] evt_in   = {29'h0, ctl.ev_trig_deny, ctl.ev_escalate, ctl.ev_misalign};
   wire logic [31:0] next_evt =
      ((evt_status & ~(wr_ev ? evt_clr : RESET_VAL)) | evt_in) & EVT_WMASK;
   wire logic [31:0] next_em  = shc_merge(evt_mask, pwdata, pstrb, EVT_WMASK);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         configuration_control <= RESET_VAL;
         handler_priority_one   <= RESET_VAL;
         handler_priority_two   <= RESET_VAL;
         handler_priority_three <= RESET_VAL;
      end else begin
         if (wr_cfg) configuration_control <= next_cfg;
         if (wr_p1) handler_priority_one <= next_p1;
         if (wr_p2) handler_priority_two <= next_p2;
         if (wr_p3) handler_priority_three <= next_p3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         handler_control_state <= RESET_VAL;
         evt_status            <= RESET_VAL;
         evt_mask              <= RESET_VAL;
      end else begin
         handler_control_state <= next_state;
         evt_status            <= next_evt;
         if (wr_em) evt_mask <= next_em;
      end
   end

   // ----------------------------------------
   // Interrupt
   // ----------------------------------------
   assign irq = |(evt_status & evt_mask);

   // ----------------------------------------
   // Core-facing fields
   // ----------------------------------------
   assign memprot_fault_priority    = handler_priority_one[7:0];
   assign bus_error_priority        = handler_priority_one[15:8];
   assign illegal_use_priority      = handler_priority_one[23:16];
   assign supervisor_call_priority  = handler_priority_two[31:24];
   assign deferred_service_priority = handler_priority_three[23:16];
   assign system_tick_priority      = handler_priority_three[31:24];
   assign handler_state             = handler_control_state[18:0];

   assign ctl.cfg_misalign = configuration_control[CFG_MISALIGN];
   assign ctl.cfg_unpriv   = configuration_control[CFG_UNPRIV];
   assign ctl.cfg_thread   = configuration_control[CFG_THREAD];
   assign ctl.handler_en   = handler_control_state[ST_EN_LO +: 3];

   // ----------------------------------------
   // Fault routing
   // ----------------------------------------
   shc_fault_route u_route (
      .pclk           (pclk),
      .presetn        (presetn),
      .ctl            (ctl),
      .acc_valid      (acc_valid),
      .acc_size       (acc_size),
      .acc_multi      (acc_multi),
      .acc_addr       (acc_addr),
      .fault_valid    (fault_valid),
      .fault_kind     (fault_kind),
      .trig_req       (trig_req),
      .trig_unpriv    (trig_unpriv),
      .ret_req        (ret_req),
      .ret_to_thread  (ret_to_thread),
      .nest_active    (nest_active),
      .misalign_fault (misalign_fault),
      .fault_take     (fault_take),
      .fault_to_hard  (fault_to_hard),
      .fault_kind_out (fault_kind_out),
      .trig_grant     (trig_grant),
      .trig_deny      (trig_deny),
      .thread_ok      (thread_ok),
      .thread_deny    (thread_deny)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_prio_low;
      (handler_priority_one & ~PRIO1_WMASK) == RESET_VAL
      && memprot_fault_priority[3:0] == 4'h0
      && system_tick_priority[3:0] == 4'h0;
   endproperty
   a_prio_low: assert property (p_prio_low) else $error("low priority bits set");

   property p_byte_write;
      wr_p1 && pstrb == 4'b0010
      |=> $stable(handler_priority_one[7:0]) && $stable(handler_priority_one[23:16])
          && bus_error_priority == ($past(pwdata[15:8]) & PRIO_KEEP);
   endproperty
   a_byte_write: assert property (p_byte_write) else $error("byte write bad");

   property p_svc_field;
      wr_p2 && pstrb == 4'hF
      |=> supervisor_call_priority == ($past(pwdata[31:24]) & PRIO_KEEP)
          && handler_priority_two[23:0] == 24'h00_0000;
   endproperty
   a_svc_field: assert property (p_svc_field) else $error("svc field bad");

   property p_p3_fields;
      wr_p3 && pstrb[3:2] == 2'b11
      |=> deferred_service_priority == ($past(pwdata[23:16]) & PRIO_KEEP)
          && system_tick_priority == ($past(pwdata[31:24]) & PRIO_KEEP);
   endproperty
   a_p3_fields: assert property (p_p3_fields) else $error("priority three bad");

   property p_reserved;
      configuration_control[31:4] == 28'h000_0000
      && configuration_control[2] == 1'b0
      && handler_control_state[31:19] == 13'h0000
      && handler_control_state[9] == 1'b0
      && handler_control_state[6:4] == 3'h0
      && handler_control_state[2] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_enable_write;
      wr_st && pstrb[2]
      |=> handler_state[18:16] == $past(pwdata[18:16]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   property p_pend_set_wins;
      core_state_set[ST_PEND_SVC] |=> handler_state[ST_PEND_SVC];
   endproperty
   a_pend_set_wins: assert property (p_pend_set_wins) else $error("pending set lost");

   property p_act_write;
      wr_st && pstrb[1:0] == 2'b11 && core_state_set == 16'h0000 && core_state_clr == 16'h0000
      |=> handler_state[ST_ACT_TICK:0] == ($past(pwdata[11:0]) & STATE_WMASK[11:0]);
   endproperty
   a_act_write: assert property (p_act_write) else $error("active write lost");

   property p_evt_sticky;
      ctl.ev_escalate |=> evt_status[EV_ESCALATE] ##1 (evt_status[EV_ESCALATE] || $past(wr_ev));
   endproperty
   a_evt_sticky: assert property (p_evt_sticky) else $error("event not held");

   property p_unmapped;
      access && !map_hit |-> pslverr && pready;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not flagged");

endmodule : shc_handler_regs

// ### test/shc_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Core exception side model
// ----------------------------------------
module shc_core_model
   import shc_pkg::*;
(
   input  logic        pclk,
   output logic        acc_valid,
   output shc_size_t   acc_size,
   output logic        acc_multi,
   output logic [1:0]  acc_addr,
   output logic        fault_valid,
   output shc_fault_t  fault_kind,
   output logic        trig_req,
   output logic        trig_unpriv,
   output logic        ret_req,
   output logic        ret_to_thread,
   output logic        nest_active,
   output logic [15:0] core_state_set,
   output logic [15:0] core_state_clr
);
   initial begin
      {acc_valid, fault_valid, trig_req, ret_req} = 4'h0;
      {acc_multi, acc_addr, trig_unpriv, ret_to_thread, nest_active} = 6'h00;
      acc_size = SHC_SZ_BYTE;
      fault_kind = SHC_FK_MEMPROT;
      {core_state_set, core_state_clr} = 32'h0000_0000;
   end
   // Request pulse, r = {access, fault, trigger, return}
   task automatic go(input logic [3:0] r, input logic [9:0] q);
      @(posedge pclk);
      {acc_valid, fault_valid, trig_req, ret_req} <= r;
      acc_size <= shc_size_t'(q[9:8]);
      {acc_multi, acc_addr} <= q[7:5];
      fault_kind <= shc_fault_t'(q[4:3]);
      {trig_unpriv, ret_to_thread, nest_active} <= q[2:0];
      @(posedge pclk);
      {acc_valid, fault_valid, trig_req, ret_req} <= 4'h0;
      acc_addr <= ~q[6:5];
      #1;
   endtask : go
   // State set and clear pulse
   task automatic st(input logic [15:0] s, input logic [15:0] c);
      @(posedge pclk);
      core_state_set <= s;
      core_state_clr <= c;
      @(posedge pclk);
      {core_state_set, core_state_clr} <= 32'h0000_0000;
      #1;
   endtask : st
endmodule : shc_core_model

// ### test/test_system_handler_control_regs.sv
`timescale 1ns/1ps
// ----------------------------------------
// Handler register bench
// ----------------------------------------
module test_system_handler_control_regs
   import shc_pkg::*;
;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, r;
   logic [3:0]        pstrb;
   logic              acc_valid, acc_multi, fault_valid, trig_req, trig_unpriv, irq;
   logic              ret_req, ret_to_thread, nest_active, misalign_fault, fault_take;
   logic              fault_to_hard, trig_grant, trig_deny, thread_ok, thread_deny;
   logic [1:0]        acc_addr;
   logic [15:0]       core_state_set, core_state_clr;
   logic [18:0]       handler_state;
   logic [7:0]        memprot_fault_priority, bus_error_priority, illegal_use_priority;
   logic [7:0]        supervisor_call_priority, deferred_service_priority;
   logic [7:0]        system_tick_priority;
   shc_size_t         acc_size;
   shc_fault_t        fault_kind, fault_kind_out;
   int                miscompares, checks;
   logic [7:0]        offs [5] = '{OFF_CFG, OFF_PRIO1, OFF_PRIO2, OFF_PRIO3, OFF_STATE};
   logic [31:0]       msk  [5] = '{32'h0000_000B, 32'h00F0_F0F0, 32'hF000_0000,
                                   32'hF0F0_0000, 32'h0007_FD8B};
   logic [6:0]        trap [7] = '{7'h12, 7'h53, 7'h65, 7'h60, 7'h33, 7'h2D, 7'h28};
   logic [2:0]        sel  [3] = '{3'h2, 3'h1, 3'h7};

   shc_handler_regs dut (.*);
   shc_core_model   core (.*);

   initial pclk = 1'b0;
   always #10 pclk = ~pclk;

   task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask : check

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 50) miscompares++;
      #1;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      xfer(1'b1, a, d, s);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0000_0000, 4'h0);
      check($sformatf("register %h", a), r, x);
   endtask : rd

   task automatic final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   initial begin
      #100000;
      miscompares++;
      final_report();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      presetn = 1'b0;
      miscompares = 0;
      checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0000_0000);
      rd(8'h1C, 32'h0000_0000);
      check("bus error", 32'(e), 32'h0000_0001);
      for (int i = 0; i < 5; i++) begin
         wr(offs[i], 32'hFFFF_FFFF);
         rd(offs[i], msk[i]);
      end
      check("prio one", {8'h00, illegal_use_priority, bus_error_priority,
                         memprot_fault_priority}, 32'h00F0_F0F0);
      check("prio two three", {supervisor_call_priority, system_tick_priority,
                               deferred_service_priority, 8'h00}, 32'hF0F0_F000);
      check("state port", 32'(handler_state), 32'h0007_FD8B);
      wr(OFF_PRIO1, 32'h0000_5A00, 4'h2);
      rd(OFF_PRIO1, 32'h00F0_50F0);
      wr(OFF_STATE, 32'h0000_0000);
      core.st(16'h8800, 16'h0000);
      rd(OFF_STATE, 32'h0000_8800);
      core.st(16'h0000, 16'h0800);
      rd(OFF_STATE, 32'h0000_8000);
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 3; k++) begin
            core.go(4'h4, {5'h00, 2'(k), 3'h0});
            check("to hard", 32'(fault_to_hard), 32'(p == 0));
            check("fault kind", 32'(fault_kind_out), 32'(k));
         end
         xfer(1'b0, OFF_STATE, 32'h0000_0000, 4'h0);
         wr(OFF_STATE, r | 32'h0007_0000);
      end
      for (int i = 0; i < 7; i++) begin
         wr(OFF_CFG, {28'h0000_000, trap[i][6], 3'h0});
         core.go(4'h8, {trap[i][5:1], 5'h00});
         check("trap", 32'({misalign_fault, fault_take}), 32'({2{trap[i][0]}}));
         check("fault kind", 32'(fault_kind_out), 32'({trap[i][0], 1'b0}));
      end
      rd(OFF_EVT, 32'h0000_0003);
      wr(OFF_EVT_MASK, 32'h0000_0001);
      check("irq", 32'(irq), 32'h0000_0001);
      wr(OFF_EVT, 32'h0000_0001);
      rd(OFF_EVT, 32'h0000_0002);
      check("irq", 32'(irq), 32'h0000_0000);
      wr(OFF_EVT_MASK, 32'h0000_0002);
      check("irq", 32'(irq), 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         wr(OFF_CFG, {30'h0000_0000, sel[i][2], sel[i][2]});
         core.go(4'h3, {7'h00, sel[i][1], 1'b1, sel[i][1]});
         check("grant", 32'({trig_grant, trig_deny}), 32'({sel[i][0], ~sel[i][0]}));
         check("thread", 32'({thread_ok, thread_deny}), 32'({sel[i][0], ~sel[i][0]}));
      end
      rd(OFF_EVT, 32'h0000_0006);
      final_report();
   end
endmodule : test_system_handler_control_regs
